// *** tal_core.sv ***
`default_nettype none
module tal_core
    import tal_pkg::*;
#(
    parameter int TCONV_CYC = TAL_TCONV_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire tal_bus_t bus_req,
    output logic [15:0] rdata,
    input wire logic bus_busy,
    input wire logic [2:0] addr_pins,
    output logic [6:0] slave_addr,
    input wire logic adc_done,
    input wire logic [8:0] adc_result,
    output logic adc_start,
    output logic adc_zone,
    output logic alert_o,
    output logic alert_oe
);
    // ========================================
    // Filter depth decode
    function automatic logic [2:0] fq_depth(input logic [1:0] f);
        case (f)
            2'h0: fq_depth = TAL_Q1;
            2'h1: fq_depth = TAL_Q2;
            2'h2: fq_depth = TAL_Q4;
            default: fq_depth = TAL_Q6;
        endcase
    endfunction

    typedef enum logic [2:0] {
        TAL_IDLE = 3'b001,
        TAL_CONV = 3'b010,
        TAL_HOLD = 3'b100
    } tal_state_t;

    tal_cfg_t cfg_q;
    logic [8:0] temp_q, high_q, low_q;
    logic sts_q, cond_q, over_arm_q, pin_act;
    logic [2:0] cnt_hi_q, cnt_lo_q;
    logic [31:0] tmr_q;
    tal_state_t st_q;
    logic [2:0] ap_s1_q, ap_s2_q;
    logic bb_s1_q, bb_s2_q;
    logic [1:0] por_q;
    logic cfg_wr, any_rd, enter_shutdown_bit, over, under, hi_hit, lo_hit;
    logic [31:0] tconv_len;
    logic rearm;
    logic [2:0] idle_run_q;

    // Pin synchronisers, first stage read only by second
    always_ff @(posedge clock) begin
        ap_s1_q <= addr_pins;
        ap_s2_q <= ap_s1_q;
        bb_s1_q <= bus_busy;
        bb_s2_q <= bb_s1_q;
    end

    // Address latched once, after sync settles
    always_ff @(posedge clock) begin
        if (rst) begin
            por_q <= 2'h0;
            slave_addr <= {TAL_ADDR_BASE, 3'h0};
        end else if (por_q != 2'h3) begin
            por_q <= por_q + 2'h1;
            if (por_q == 2'h2) slave_addr <= {TAL_ADDR_BASE, ap_s2_q};
        end
    end

    assign cfg_wr = bus_req.wr && bus_req.addr == TAL_REG_CFG;
    assign any_rd = bus_req.rd;
    assign enter_shutdown_bit = cfg_wr && bus_req.wdata[TAL_CFG_SHUTDOWN_BIT] && !cfg_q.shutdown_bit;

    // Register writes; limits take the top nine bits of the word, all allowed in shutdown
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_q <= TAL_CFG_RST;
            high_q <= TAL_HIGH_RST;
            low_q <= TAL_LOW_RST;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                TAL_REG_CFG: cfg_q <= bus_req.wdata[6:0];
                TAL_REG_LOW: low_q <= bus_req.wdata[15:TAL_WORD_SHIFT];
                TAL_REG_HIGH: high_q <= bus_req.wdata[15:TAL_WORD_SHIFT];
                default: ;
            endcase
        end
    end

    // Read data next cycle; temperature and limits left-justified, low bits zero
    always_ff @(posedge clock) begin
        if (rst) rdata <= 16'h0000;
        else if (any_rd) begin
            case (bus_req.addr)
                TAL_REG_TEMP: rdata <= {temp_q, 7'h00};
                TAL_REG_CFG: rdata <= {8'h00, sts_q, cfg_q};
                TAL_REG_LOW: rdata <= {low_q, 7'h00};
                default: rdata <= {high_q, 7'h00};
            endcase
        end
    end

    // Remote zone uses double timing budget
    assign tconv_len = cfg_q.zone ? (TCONV_CYC * 2) : TCONV_CYC;

    // Conversion scheduler: abort on access, restart after
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= TAL_IDLE;
            tmr_q <= 32'h0;
            adc_start <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            case (st_q)
                TAL_IDLE: if (!cfg_q.shutdown_bit && !bb_s2_q) begin
                    st_q <= TAL_CONV;
                    tmr_q <= 32'h0;
                    adc_start <= 1'b1;
                end
                TAL_CONV: begin
                    if (cfg_q.shutdown_bit) st_q <= TAL_IDLE;
                    else if (bb_s2_q) st_q <= TAL_HOLD;
                    else if (cfg_wr) begin
                        tmr_q <= 32'h0;
                        adc_start <= 1'b1;
                    end else if (adc_done) st_q <= TAL_IDLE;
                    else tmr_q <= tmr_q + 32'h1;
                end
                TAL_HOLD: if (!bb_s2_q) st_q <= TAL_IDLE;
                default: st_q <= TAL_IDLE;
            endcase
        end
    end
    // Zone follows a settings write on the same edge as the restart strobe,
    // so the converter never starts a run on the old zone
    always_ff @(posedge clock) begin
        if (rst) adc_zone <= 1'b0;
        else if (cfg_wr) adc_zone <= bus_req.wdata[TAL_CFG_ZONE];
        else adc_zone <= cfg_q.zone;
    end

    // Result register updated only by a completed conversion
    wire conv_ok = st_q == TAL_CONV && adc_done && !bb_s2_q && !cfg_q.shutdown_bit && !cfg_wr;
    always_ff @(posedge clock) begin
        if (rst) temp_q <= TAL_TEMP_RST;
        else if (conv_ok) temp_q <= adc_result;
    end

    // Signed compares of fresh result
    assign hi_hit = $signed(adc_result) > $signed(high_q);
    assign lo_hit = $signed(adc_result) < $signed(low_q);

    // Consecutive counters; a miss restarts the count
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_hi_q <= 3'h0;
            cnt_lo_q <= 3'h0;
        end else if (conv_ok) begin
            cnt_hi_q <= hi_hit ? ((cnt_hi_q < TAL_Q6) ? cnt_hi_q + 3'h1 : cnt_hi_q) : 3'h0;
            cnt_lo_q <= lo_hit ? ((cnt_lo_q < TAL_Q6) ? cnt_lo_q + 3'h1 : cnt_lo_q) : 3'h0;
        end
    end
    assign over = conv_ok && hi_hit && (cnt_hi_q + 3'h1 >= fq_depth(cfg_q.fq));
    assign under = conv_ok && lo_hit && (cnt_lo_q + 3'h1 >= fq_depth(cfg_q.fq));

    // Clearing the mode bit while in interrupt mode re-arms for over-temperature
    assign rearm = cfg_wr && !bus_req.wdata[TAL_CFG_MODE] && cfg_q.mode;

    // Event arming: which kind may fire next
    always_ff @(posedge clock) begin
        if (rst) over_arm_q <= 1'b1;
        else if (rearm) over_arm_q <= 1'b1;
        else if (over_arm_q && over) over_arm_q <= 1'b0;
        else if (!over_arm_q && under) over_arm_q <= 1'b1;
    end

    // Comparator state
    always_ff @(posedge clock) begin
        if (rst) cond_q <= 1'b0;
        else if (!cond_q && over) cond_q <= 1'b1;
        else if (cond_q && under) cond_q <= 1'b0;
    end

    // Status latch: set wins over read clear
    wire evt = over_arm_q ? over : under;
    always_ff @(posedge clock) begin
        if (rst) sts_q <= 1'b0;
        else if (evt) sts_q <= 1'b1;
        else if (any_rd || (enter_shutdown_bit && cfg_q.mode)) sts_q <= 1'b0;
    end

    // Alert pin: open drain, oe high while sinking
    always_comb begin
        pin_act = cfg_q.mode ? sts_q : cond_q;
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            alert_o <= 1'b0;
            alert_oe <= 1'b0;
        end else begin
            alert_o <= 1'b0;
            alert_oe <= !cfg_q.mask && (pin_act ^ cfg_q.alert_polarity_bit);
        end
    end

    // ========================================
    // Checks
    // Slack covers the strobe round trip through the converter
    localparam logic [31:0] CONV_SLACK = 32'h4;

    // Idle cycles in a row while conversions are allowed; more than one is a gap
    always_ff @(posedge clock) begin
        if (rst) idle_run_q <= 3'h0;
        else if (st_q == TAL_IDLE && !cfg_q.shutdown_bit && !bb_s2_q) begin
            if (idle_run_q != 3'h7) idle_run_q <= idle_run_q + 3'h1;
        end else idle_run_q <= 3'h0;
    end

    // Scheduler steps
    sequence s_idle_go;
        st_q == TAL_IDLE && !cfg_q.shutdown_bit && !bb_s2_q;
    endsequence
    sequence s_started;
        adc_start && st_q == TAL_CONV;
    endsequence
    sequence s_abort;
        st_q == TAL_CONV && bb_s2_q && !cfg_q.shutdown_bit;
    endsequence
    sequence s_in_hold;
        st_q == TAL_HOLD;
    endsequence
    sequence s_hold_done;
        st_q == TAL_HOLD && !bb_s2_q;
    endsequence

    // Result only moves on an accepted conversion
    a_temp_hold: assert property (@(posedge clock) disable iff (rst)
        !conv_ok |=> $stable(temp_q))
        else $error("result changed without conversion");

    // No start strobe once shut down
    a_shutdown_bit_stop: assert property (@(posedge clock) disable iff (rst)
        cfg_q.shutdown_bit |=> !adc_start)
        else $error("start in shutdown");

    // Armed for over-temperature straight out of reset
    a_rst_arm: assert property (@(posedge clock)
        $fell(rst) |-> over_arm_q)
        else $error("not armed over");

    // Power-up settings and limits
    a_rst_vals: assert property (@(posedge clock)
        $fell(rst) |-> cfg_q == TAL_CFG_RST && high_q == TAL_HIGH_RST
            && low_q == TAL_LOW_RST && !sts_q && !alert_oe)
        else $error("power-up values wrong");

    // Any accepted event sets the status
    a_sts_set: assert property (@(posedge clock) disable iff (rst)
        evt |=> sts_q)
        else $error("status not set");

    // Status is set even while the pin is masked
    a_sts_unmask: assert property (@(posedge clock) disable iff (rst)
        evt && cfg_q.mask |=> sts_q)
        else $error("masked event lost");

    // Unmasked interrupt status drives an active-low pin
    a_int_pin: assert property (@(posedge clock) disable iff (rst)
        cfg_q.mode && !cfg_q.mask && sts_q && !cfg_q.alert_polarity_bit |=> alert_oe)
        else $error("interrupt not driven");

    // Mask releases the pin whatever the state
    a_mask_rel: assert property (@(posedge clock) disable iff (rst)
        cfg_q.mask |=> !alert_oe)
        else $error("masked pin driven");

    // A read clears the status unless an event lands with it
    a_rd_clear: assert property (@(posedge clock) disable iff (rst)
        any_rd && !evt |=> !sts_q)
        else $error("read did not clear");

    // Status holds until read or a shutdown in interrupt mode
    a_int_hold: assert property (@(posedge clock) disable iff (rst)
        sts_q && !any_rd && !(enter_shutdown_bit && cfg_q.mode) |=> sts_q)
        else $error("status dropped by itself");

    // Shutdown in interrupt mode clears the status
    a_shutdown_bit_clear: assert property (@(posedge clock) disable iff (rst)
        enter_shutdown_bit && cfg_q.mode && !evt |=> !sts_q)
        else $error("shutdown kept status");

    // Shutdown keeps the cause of the last event
    a_keep_cause: assert property (@(posedge clock) disable iff (rst)
        enter_shutdown_bit && !rearm |=> $stable(over_arm_q))
        else $error("shutdown lost cause");

    // Comparator sets on a filtered over event
    a_cmp_set: assert property (@(posedge clock) disable iff (rst)
        over && !cond_q |=> cond_q)
        else $error("comparator missed");

    // Comparator clears on a filtered under event
    a_cmp_clear: assert property (@(posedge clock) disable iff (rst)
        under && cond_q |=> !cond_q)
        else $error("comparator not cleared");

    // Comparator holds until an under event
    a_cmp_keep: assert property (@(posedge clock) disable iff (rst)
        cond_q && !under |=> cond_q)
        else $error("comparator dropped early");

    // After an over event only an under event or a mode toggle re-arms
    a_arm_keep: assert property (@(posedge clock) disable iff (rst)
        !over_arm_q && !under && !rearm |=> !over_arm_q)
        else $error("re-armed without crossing");

    // After an under event only an over event flips the arming
    a_arm_over: assert property (@(posedge clock) disable iff (rst)
        over_arm_q && !over |=> over_arm_q)
        else $error("arming flipped without event");

    // Mode toggle re-arms for over-temperature
    a_rearm: assert property (@(posedge clock) disable iff (rst)
        rearm |=> over_arm_q)
        else $error("toggle did not re-arm");

    // A miss restarts the over count
    a_hi_reset: assert property (@(posedge clock) disable iff (rst)
        conv_ok && !hi_hit |=> cnt_hi_q == 3'h0)
        else $error("over count not restarted");

    // A miss restarts the under count
    a_lo_reset: assert property (@(posedge clock) disable iff (rst)
        conv_ok && !lo_hit |=> cnt_lo_q == 3'h0)
        else $error("under count not restarted");

    // Depth one accepts the first hit
    a_fq_one: assert property (@(posedge clock) disable iff (rst)
        conv_ok && hi_hit && cfg_q.fq == 2'h0 |-> over)
        else $error("depth one missed");

    // Depth six refuses the first five hits
    a_fq_six: assert property (@(posedge clock) disable iff (rst)
        conv_ok && hi_hit && cfg_q.fq == 2'h3 && cnt_hi_q < 3'h5 |-> !over)
        else $error("depth six fired early");

    // Idle never waits while conversions are allowed
    a_start_go: assert property (@(posedge clock) disable iff (rst)
        s_idle_go |=> s_started)
        else $error("conversion not started");

    // No gap between conversions
    a_no_gap: assert property (@(posedge clock) disable iff (rst)
        idle_run_q <= 3'h1)
        else $error("gap between conversions");

    // A bus access aborts the running conversion
    a_busy_abort: assert property (@(posedge clock) disable iff (rst)
        s_abort |=> s_in_hold)
        else $error("access did not abort");

    // End of the access returns the scheduler to idle
    a_hold_end: assert property (@(posedge clock) disable iff (rst)
        s_hold_done |=> st_q == TAL_IDLE)
        else $error("hold not left");

    // Conversion ends within its zone budget
    a_conv_len: assert property (@(posedge clock) disable iff (rst)
        st_q == TAL_CONV |-> tmr_q <= tconv_len + CONV_SLACK)
        else $error("conversion overran");

    // Shutdown leaves the scheduler idle, so no diode checks run
    a_shutdown_bit_idle: assert property (@(posedge clock) disable iff (rst)
        cfg_q.shutdown_bit && st_q != TAL_HOLD |=> st_q == TAL_IDLE)
        else $error("converting in shutdown");

    // A settings write restarts the running conversion
    a_cfg_restart: assert property (@(posedge clock) disable iff (rst)
        st_q == TAL_CONV && cfg_wr && !cfg_q.shutdown_bit && !bb_s2_q |=> adc_start)
        else $error("settings write did not restart");

    // Zone output follows the written zone bit
    a_zone_follow: assert property (@(posedge clock) disable iff (rst)
        cfg_wr |=> adc_zone == $past(bus_req.wdata[TAL_CFG_ZONE]))
        else $error("zone not updated");

    // An accepted conversion loads the converter's result
    a_result_load: assert property (@(posedge clock) disable iff (rst)
        conv_ok |=> temp_q == $past(adc_result))
        else $error("result not loaded");

    // Result reads back left-justified
    a_rd_temp: assert property (@(posedge clock) disable iff (rst)
        any_rd && bus_req.addr == TAL_REG_TEMP |=> rdata == {$past(temp_q), 7'h00})
        else $error("result read wrong");

    // Address stays fixed once latched
    a_addr_fixed: assert property (@(posedge clock) disable iff (rst)
        por_q == 2'h3 |=> $stable(slave_addr))
        else $error("address changed");
endmodule
`default_nettype wire

// *** tal_pkg.sv ***
`default_nettype none
package tal_pkg;
    // ========================================
    // Register indices (command byte values)
    localparam logic [1:0] TAL_REG_TEMP = 2'h0;
    localparam logic [1:0] TAL_REG_CFG = 2'h1;
    localparam logic [1:0] TAL_REG_LOW = 2'h2;
    localparam logic [1:0] TAL_REG_HIGH = 2'h3;
    // ========================================
    // Settings fields
    localparam int TAL_CFG_SHUTDOWN_BIT = 0;
    localparam int TAL_CFG_MODE = 1;
    localparam int TAL_CFG_POL = 2;
    localparam int TAL_CFG_FQ_LO = 3;
    localparam int TAL_CFG_ZONE = 5;
    localparam int TAL_CFG_MASK = 6;
    localparam int TAL_CFG_STS = 7;
    localparam int TAL_WORD_SHIFT = 7;
    // ========================================
    // Reset values
    localparam logic [8:0] TAL_HIGH_RST = 9'h0a0;
    localparam logic [8:0] TAL_LOW_RST = 9'h096;
    localparam logic [8:0] TAL_TEMP_RST = 9'h000;
    localparam logic [6:0] TAL_CFG_RST = 7'h00;
    localparam logic [3:0] TAL_ADDR_BASE = 4'h9;
    // ========================================
    // Timing and filter depths
    localparam int TAL_CLK_MHZ = 125;
    localparam int TAL_TCONV_US = 100;
    localparam int TAL_TCONV_CYC = TAL_TCONV_US * TAL_CLK_MHZ;
    localparam logic [2:0] TAL_Q1 = 3'h1;
    localparam logic [2:0] TAL_Q2 = 3'h2;
    localparam logic [2:0] TAL_Q4 = 3'h4;
    localparam logic [2:0] TAL_Q6 = 3'h6;

    typedef struct packed {
        logic mask;
        logic zone;
        logic [1:0] fq;
        logic alert_polarity_bit;
        logic mode;
        logic shutdown_bit;
    } tal_cfg_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tal_bus_t;
endpackage
`default_nettype wire

// *** tal_adc_model.sv ***
`default_nettype none
// ========================================
// Converter model
module tal_adc_model #(
    parameter int CONV = 20
) (
    input wire logic clock,
    input wire logic adc_start,
    input wire logic adc_zone,
    input wire logic [8:0] next_temp,
    output var logic adc_done,
    output var logic [8:0] adc_result
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        adc_done = 1'b0;
        adc_result = 9'h000;
    end
    // A start always reloads the count, so a restarted run never reports
    always @(posedge clock) begin
        adc_done <= 1'b0;
        adc_result <= ~adc_result; // No stale value outside the strobe
        if (adc_start) begin
            cnt <= adc_zone ? 2 * CONV : CONV;
        end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_result <= next_temp;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
// ========================================
// Bench top
module testbench;
    import tal_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic bus_busy = 1'b0;
    logic [2:0] addr_pins = 3'h5;
    logic [8:0] next_temp = 9'h032;
    tal_bus_t bus = '0;
    logic [15:0] rdata;
    logic [6:0] slave_addr;
    logic adc_done, adc_start, adc_zone, alert_o, alert_oe, pend = 1'b0;
    logic [8:0] adc_result, v;
    logic [15:0] exp_q[$];
    int errors = 0, cmp_count = 0, cyc = 0, n = 0, seed = 28043;
    int depth[4] = '{1, 2, 4, 6};
    wire logic int_pin;
    assign int_pin = alert_oe ? alert_o : 1'b1; // Pulled up when released
    always #4 clock = ~clock;
    tal_core #(.TCONV_CYC(CONV)) u_tal_core (.clock(clock), .rst(rst), .bus_req(bus),
        .rdata(rdata), .bus_busy(bus_busy), .addr_pins(addr_pins), .slave_addr(slave_addr),
        .adc_done(adc_done), .adc_result(adc_result), .adc_start(adc_start),
        .adc_zone(adc_zone), .alert_o(alert_o), .alert_oe(alert_oe));
    tal_adc_model #(.CONV(CONV)) u_tal_adc_model (.clock(clock), .adc_start(adc_start),
        .adc_zone(adc_zone), .next_temp(next_temp), .adc_done(adc_done),
        .adc_result(adc_result));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // The extra edge keeps a strobe from being set twice in one step
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        @(posedge clock);
    endtask
    // Bounded by the cycle ceiling below
    task automatic conv(input int k);
        repeat (k) begin
            do @(posedge clock); while (adc_done !== 1'b1);
        end
        repeat (4) @(posedge clock);
    endtask
    // Read data are checked in the cycle after the strobe and hold until the next read
    always @(posedge clock) begin
        if (pend) check("rdata", rdata, exp_q.pop_front());
        pend <= bus.rd;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(TAL_REG_TEMP, 16'h0000);
        repeat (2) @(posedge clock);
        addr_pins <= 3'h2;
        conv(2);
        check("slave_addr", slave_addr, {9'h009, 3'h5});
        rd(TAL_REG_CFG, 16'h0000);
        rd(TAL_REG_LOW, {9'h096, 7'h00});
        rd(TAL_REG_HIGH, {9'h0a0, 7'h00});
        rd(TAL_REG_TEMP, {9'h032, 7'h00});
        next_temp <= 9'h0a1;
        conv(2);
        check("pin", int_pin, 1'b0);
        rd(TAL_REG_TEMP, {9'h0a1, 7'h00});
        next_temp <= 9'h1ce;
        conv(2);
        check("pin", int_pin, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(TAL_REG_CFG, {11'h000, i[1:0], 3'h0});
            next_temp <= 9'h0a1;
            conv(depth[i] - 1);
            check("pin", int_pin, 1'b1);
            conv(1);
            check("pin", int_pin, 1'b0);
            next_temp <= 9'h1ce;
            conv(depth[i]);
            check("pin", int_pin, 1'b1);
        end
        // Last event over in interrupt mode, then a mode toggle with a cold reading
        wr(TAL_REG_CFG, 16'h0002);
        next_temp <= 9'h0a1;
        conv(2);
        next_temp <= 9'h1ce;
        wr(TAL_REG_CFG, 16'h0000);
        wr(TAL_REG_CFG, 16'h0002);
        rd(TAL_REG_CFG, 16'h0082);
        conv(2);
        check("pin", int_pin, 1'b1);
        next_temp <= 9'h0a1;
        conv(1);
        check("pin", int_pin, 1'b0);
        conv(2);
        check("pin", int_pin, 1'b0);
        rd(TAL_REG_CFG, 16'h0082);
        conv(2);
        check("pin", int_pin, 1'b1);
        next_temp <= 9'h1ce;
        wr(TAL_REG_CFG, 16'h0042);
        conv(2);
        check("pin", int_pin, 1'b1);
        rd(TAL_REG_CFG, 16'h00c2);
        wr(TAL_REG_CFG, 16'h0006);
        repeat (4) @(posedge clock);
        check("pin", int_pin, 1'b0);
        next_temp <= 9'h0a1;
        conv(2);
        check("pin", int_pin, 1'b1);
        wr(TAL_REG_CFG, 16'h0007);
        repeat (4) @(posedge clock);
        check("pin", int_pin, 1'b0);
        repeat (100) begin
            @(posedge clock);
            n += adc_start;
        end
        check("starts", n[15:0], 16'h0000);
        rd(TAL_REG_CFG, 16'h0007);
        repeat (4) begin
            v = 9'($random(seed));
            wr(TAL_REG_HIGH, {v, 7'h7f});
            rd(TAL_REG_HIGH, {v, 7'h00});
        end
        next_temp <= 9'h032;
        wr(TAL_REG_CFG, 16'h0020);
        check("zone", adc_zone, 1'b1);
        conv(1);
        rd(TAL_REG_TEMP, {9'h032, 7'h00});
        next_temp <= 9'h1b0;
        bus_busy <= 1'b1;
        repeat (60) @(posedge clock);
        rd(TAL_REG_TEMP, {9'h032, 7'h00});
        bus_busy <= 1'b0;
        conv(1);
        rd(TAL_REG_TEMP, {9'h1b0, 7'h00});
        check("temp_byte", {8'h00, rdata[15:8]}, 16'h00d8);
        print_verdict();
    end
endmodule
`default_nettype wire
